// ### cfmi_pkg.sv
// Purpose: Shared constants and types for the charger fault monitor
// Assumes: 20 MHz clock, 32-bit Avalon-MM register bus, byte addressing
// Notes:   Register byte address is four times the register index
package cfmi_pkg;

	localparam int unsigned CLK_HZ      = 20_000_000;
	localparam int unsigned MIN_SECONDS = 60;
	// Cycles per minute of charging time
	localparam int unsigned CYC_PER_MIN = CLK_HZ * MIN_SECONDS;

	// Trickle check point, in minutes
	localparam logic [9:0] CHECK_MIN_MINUTES = 10'h01E;
	localparam logic [9:0] LIMIT_BASE_MIN    = 10'h03C;
	localparam logic [9:0] LIMIT_STEP_MIN    = 10'h01E;

	// Register indexes and address layout
	localparam int unsigned ADDR_W        = 10;
	localparam logic [7:0]  IDX_FLAGS     = 8'h19;
	localparam logic [7:0]  IDX_MASKS     = 8'h21;
	localparam logic [7:0]  IDX_CONTROL   = 8'h40;
	localparam logic [7:0]  IDX_SYSSTAT   = 8'h41;

	// Event flag bit positions
	localparam int unsigned FB_HOT     = 15;
	localparam int unsigned FB_COLD    = 14;
	localparam int unsigned FB_FAIL    = 13;
	localparam int unsigned FB_TIMEOUT = 12;
	localparam int unsigned FB_FINAL   = 11;
	localparam int unsigned FB_STARTED = 10;
	localparam int unsigned FB_FASTRDY = 9;
	localparam int unsigned FB_LT_HIGH = 2;
	localparam int unsigned FB_LT_MID  = 1;
	localparam int unsigned FB_LT_LOW  = 0;
	localparam logic [15:0] FLAG_VALID = 16'hFE07;

	localparam logic [15:0] MASK_RESET = 16'hFFFF;

	// Control register fields
	localparam int unsigned CB_CHG_EN     = 0;
	localparam int unsigned CB_FAST_SEL   = 1;
	localparam int unsigned CB_TRK_PAUSE  = 2;
	localparam int unsigned CB_USB_SUSP   = 3;
	localparam int unsigned CB_LIMIT_LSB  = 4;
	localparam int unsigned LIMIT_W       = 4;
	localparam logic [7:0]  CONTROL_RESET = 8'h05;

	// System status register fields
	localparam int unsigned SB_WARN     = 0;
	localparam int unsigned SB_SHUT     = 1;
	localparam int unsigned SB_PAUSED   = 2;
	localparam int unsigned SB_STATE    = 4;

	typedef enum logic [2:0] {
		CFMI_IDLE,
		CFMI_TRICKLE,
		CFMI_FAST,
		CFMI_FAIL,
		CFMI_SHUTDOWN
	} cfmi_state_e;

	// Analogue comparator and sensor levels, all synchronous
	typedef struct packed {
		logic die_warn;
		logic die_shutdown;
		logic batt_hot;
		logic batt_cold;
		logic batt_lt_high;
		logic batt_lt_mid;
		logic batt_lt_low;
		logic batt_present;
		logic wall_present;
		logic usb_present;
		logic fast_ready;
		logic final_stage;
		logic timeout;
	} cfmi_sense_s;

endpackage

// ### cfmi_charger_fault_monitor.sv
// Purpose: Charger fault supervision, event flags and summary interrupt
// Assumes: Sensor levels synchronous to clock; Avalon-MM slave, byte addresses
// Notes:   One request is answered per two cycles; outputs are registered
// Contract
// RULE1 - Die warning sets warning flag and pauses charging; trickle pause is programmable
// RULE2 - Charging resumes once die temperature falls below warning level
// RULE3 - Die shutdown level sets shutdown flag, ends charging, shuts system down
// RULE4 - Trickle check at later of thirty minutes or quarter of time limit
// RULE5 - Battery below low threshold at check stops charging, sets defect flag
// RULE6 - Battery rising above low threshold clears the failure
// RULE7 - Supply reapplied or USB suspend command also clears the failure
// RULE8 - Cleared failure returns charger to idle; restart if conditions hold
// RULE9 - Fast charge with battery below low threshold drops to trickle at once
// RULE10 - Summary interrupt is OR of all unmasked event flags
// RULE11 - Losing wall or USB with battery present sets mid and low flags
// RULE12 - Host should ignore undervoltage flags when feedback flags coincide
// RULE13 - Flags set on rising edge of condition, cleared when status read
// RULE14 - Flags at bits 15 hot, 14 cold, 13 fail, 12 timeout, 11-9
// RULE15 - Below-high flag bit 2, below-mid bit 1, below-low bit 0
// RULE16 - Sixteen-bit mask mirrors flags; a one blocks that flag's interrupt
// RULE17 - Hot or cold battery suspends charging; trickle resumes when normal
// RULE18 - Masked flags still set; mask only gates the interrupt
// RULE19 - Rising edge in the read cycle keeps its flag set
//
// The Avalon-MM interface to the registers was left to the implementer.
module cfmi_charger_fault_monitor #(
	parameter int unsigned MIN_CYC = cfmi_pkg::CYC_PER_MIN
) (
	input  wire logic                        clock,
	input  wire logic                        rst,
	input  wire logic [cfmi_pkg::ADDR_W-1:0] address,
	input  wire logic                        read,
	input  wire logic                        write,
	input  wire logic [31:0]                 writedata,
	input  wire logic [3:0]                  byteenable,
	output logic      [31:0]                 readdata,
	output logic                             waitrequest,
	input  wire cfmi_pkg::cfmi_sense_s       sense,
	output logic                             charge_enable,
	output logic                             trickle_mode,
	output logic                             fast_mode,
	output logic                             system_shutdown,
	output logic                             charger_summary_irq
);

	// Bus handshake: answer one cycle after the request is seen
	logic        ack_reg;
	logic        ack_next;
	logic [7:0]  index;
	logic        sel_flags;
	logic        sel_masks;
	logic        sel_ctrl;
	logic        sel_sys;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] rd_value;

	assign ack_next  = (read | write) & ~ack_reg;
	assign index     = address[cfmi_pkg::ADDR_W-1:2];
	assign sel_flags = index == cfmi_pkg::IDX_FLAGS;
	assign sel_masks = index == cfmi_pkg::IDX_MASKS;
	assign sel_ctrl  = index == cfmi_pkg::IDX_CONTROL;
	assign sel_sys   = index == cfmi_pkg::IDX_SYSSTAT;
	assign wr_hit    = write & ack_reg;
	assign rd_hit    = read & ack_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
		end
	end

	// Software registers
	logic [15:0] mask_reg;
	logic [15:0] mask_next;
	logic [7:0]  ctrl_reg;
	logic [7:0]  ctrl_next;
	logic [15:0] wr_low;
	logic [7:0]  ctrl_wr;

	assign wr_low = {byteenable[1] ? writedata[15:8] : mask_reg[15:8],
		byteenable[0] ? writedata[7:0] : mask_reg[7:0]};
	assign ctrl_wr = byteenable[0] ? writedata[7:0] : ctrl_reg;
	assign mask_next = (wr_hit & sel_masks) ? wr_low : mask_reg;
	assign ctrl_next = (wr_hit & sel_ctrl) ? ctrl_wr : ctrl_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			mask_reg <= cfmi_pkg::MASK_RESET;
			ctrl_reg <= cfmi_pkg::CONTROL_RESET;
		end else begin
			mask_reg <= mask_next;
			ctrl_reg <= ctrl_next;
		end
	end

	logic                          cfg_chg_en;
	logic                          cfg_fast_sel;
	logic                          cfg_trk_pause;
	logic                          cfg_usb_susp;
	logic [cfmi_pkg::LIMIT_W-1:0]  charge_time_limit;

	assign cfg_chg_en        = ctrl_reg[cfmi_pkg::CB_CHG_EN];
	assign cfg_fast_sel      = ctrl_reg[cfmi_pkg::CB_FAST_SEL];
	assign cfg_trk_pause     = ctrl_reg[cfmi_pkg::CB_TRK_PAUSE];
	assign cfg_usb_susp      = ctrl_reg[cfmi_pkg::CB_USB_SUSP];
	assign charge_time_limit =
		ctrl_reg[cfmi_pkg::CB_LIMIT_LSB +: cfmi_pkg::LIMIT_W];

	// Minute tick from a divider; a minute is far too long to simulate, so
	// the count is a parameter of the module scope
	logic [31:0] div_reg;
	logic        minute_tick;
	logic        timer_run;

	assign minute_tick = div_reg == 32'(MIN_CYC - 1);

	always_ff @(posedge clock) begin
		if (rst || !timer_run || minute_tick) begin
			div_reg <= 32'h0000_0000;
		end else begin
			div_reg <= div_reg + 32'h0000_0001;
		end
	end

	// Charger state
	// Local names for the package states keep the state logic readable
	localparam cfmi_pkg::cfmi_state_e CFMI_IDLE     = cfmi_pkg::CFMI_IDLE;
	localparam cfmi_pkg::cfmi_state_e CFMI_TRICKLE  = cfmi_pkg::CFMI_TRICKLE;
	localparam cfmi_pkg::cfmi_state_e CFMI_FAST     = cfmi_pkg::CFMI_FAST;
	localparam cfmi_pkg::cfmi_state_e CFMI_FAIL     = cfmi_pkg::CFMI_FAIL;
	localparam cfmi_pkg::cfmi_state_e CFMI_SHUTDOWN = cfmi_pkg::CFMI_SHUTDOWN;
	cfmi_pkg::cfmi_state_e state_reg;
	cfmi_pkg::cfmi_state_e state_next;
	logic [9:0]  min_reg;
	logic [9:0]  limit_min;
	logic [9:0]  quarter_min;
	logic [9:0]  check_min;
	logic        check_due;
	logic        supply_any;
	logic        supply_prev_reg;
	logic        wall_prev_reg;
	logic        usb_prev_reg;
	logic        supply_back;
	logic        supply_lost;
	logic        temp_hold;
	logic        die_hold;
	logic        paused;
	logic        start_ok;
	logic        fail_clear;

	assign limit_min = cfmi_pkg::LIMIT_BASE_MIN
		+ 10'(charge_time_limit) * cfmi_pkg::LIMIT_STEP_MIN;
	assign quarter_min = limit_min >> 2;
	// Later of the two times applies
	assign check_min = (quarter_min > cfmi_pkg::CHECK_MIN_MINUTES) ? // RULE4
		quarter_min : cfmi_pkg::CHECK_MIN_MINUTES;
	assign check_due = (state_reg == CFMI_TRICKLE) && (min_reg >= check_min); // RULE4

	assign supply_any  = sense.wall_present | sense.usb_present;
	assign supply_back = supply_any & ~supply_prev_reg;
	// A supply drop with the cell attached pulls the rail briefly
	assign supply_lost = sense.batt_present & // RULE11
		((wall_prev_reg & ~sense.wall_present) | (usb_prev_reg & ~sense.usb_present));

	assign temp_hold = sense.batt_hot | sense.batt_cold; // RULE17
	// Warning pause is optional only in trickle mode
	assign die_hold = sense.die_warn & // RULE1
		((state_reg == CFMI_FAST) | cfg_trk_pause);
	assign paused = temp_hold | die_hold; // RULE2
	assign start_ok = cfg_chg_en & supply_any & ~cfg_usb_susp;
	assign fail_clear = ~sense.batt_lt_low | supply_back | cfg_usb_susp; // RULE6 RULE7

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CFMI_IDLE: begin
				if (start_ok) begin
					state_next = CFMI_TRICKLE;
				end
			end
			CFMI_TRICKLE: begin
				if (check_due && sense.batt_lt_low) begin
					state_next = CFMI_FAIL; // RULE5
				end else if (!start_ok) begin
					state_next = CFMI_IDLE;
				end else if (cfg_fast_sel && sense.fast_ready && !paused
					&& !sense.batt_lt_low) begin
					state_next = CFMI_FAST;
				end
			end
			CFMI_FAST: begin
				if (!start_ok) begin
					state_next = CFMI_IDLE;
				end else if (sense.batt_lt_low || temp_hold) begin
					state_next = CFMI_TRICKLE; // RULE9 RULE17
				end
			end
			CFMI_FAIL: begin
				if (fail_clear) begin
					state_next = CFMI_IDLE; // RULE8
				end
			end
			CFMI_SHUTDOWN: begin
				state_next = CFMI_SHUTDOWN;
			end
			default: begin
				state_next = CFMI_IDLE;
			end
		endcase
		if (sense.die_shutdown) begin
			state_next = CFMI_SHUTDOWN; // RULE3
		end
	end

	assign timer_run = (state_reg == CFMI_TRICKLE) && !paused;

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg       <= CFMI_IDLE;
			supply_prev_reg <= 1'b0;
			wall_prev_reg   <= 1'b0;
			usb_prev_reg    <= 1'b0;
		end else begin
			state_reg       <= state_next;
			supply_prev_reg <= supply_any;
			wall_prev_reg   <= sense.wall_present;
			usb_prev_reg    <= sense.usb_present;
		end
	end

	// Minutes in trickle restart on every entry, so a fall back from fast
	// gets a full check interval
	always_ff @(posedge clock) begin
		if (rst || state_reg != CFMI_TRICKLE) begin
			min_reg <= 10'h000;
		end else if (minute_tick && min_reg != 10'h3FF) begin
			min_reg <= min_reg + 10'h001;
		end
	end

	// Event flags
	logic [15:0] cond;
	logic [15:0] cond_prev_reg;
	logic [15:0] rise;
	logic [15:0] flags_reg;
	logic [15:0] flags_next;
	logic        flags_clr;

	always_comb begin
		cond = 16'h0000;
		cond[cfmi_pkg::FB_HOT]     = sense.batt_hot; // RULE14
		cond[cfmi_pkg::FB_COLD]    = sense.batt_cold;
		cond[cfmi_pkg::FB_FAIL]    = state_reg == CFMI_FAIL;
		cond[cfmi_pkg::FB_TIMEOUT] = sense.timeout;
		cond[cfmi_pkg::FB_FINAL]   = sense.final_stage;
		cond[cfmi_pkg::FB_STARTED] = (state_reg == CFMI_TRICKLE)
			|| (state_reg == CFMI_FAST);
		cond[cfmi_pkg::FB_FASTRDY] = sense.fast_ready;
		cond[cfmi_pkg::FB_LT_HIGH] = sense.batt_lt_high; // RULE15
		cond[cfmi_pkg::FB_LT_MID]  = sense.batt_lt_mid;
		cond[cfmi_pkg::FB_LT_LOW]  = sense.batt_lt_low;
	end

	always_comb begin
		rise = cond & ~cond_prev_reg; // RULE13
		rise[cfmi_pkg::FB_LT_MID] = rise[cfmi_pkg::FB_LT_MID] | supply_lost; // RULE11
		rise[cfmi_pkg::FB_LT_LOW] = rise[cfmi_pkg::FB_LT_LOW] | supply_lost; // RULE11
	end

	assign flags_clr  = rd_hit & sel_flags; // RULE13
	// Set wins over the read clear; mask plays no part here. Only bits the
	// host was shown are cleared, so an edge between capture and clear stays
	assign flags_next = ((flags_reg & ~({16{flags_clr}} & readdata[15:0])) // RULE19
		| rise) & cfmi_pkg::FLAG_VALID; // RULE18

	always_ff @(posedge clock) begin
		if (rst) begin
			flags_reg     <= 16'h0000;
			cond_prev_reg <= 16'h0000;
		end else begin
			flags_reg     <= flags_next;
			cond_prev_reg <= cond;
		end
	end

	// Die temperature flags kept beside the charger flags
	logic warn_reg;
	logic shut_reg;
	logic warn_prev_reg;
	logic shut_prev_reg;
	logic sys_clr;

	assign sys_clr = rd_hit & sel_sys;

	always_ff @(posedge clock) begin
		if (rst) begin
			warn_reg      <= 1'b0;
			shut_reg      <= 1'b0;
			warn_prev_reg <= 1'b0;
			shut_prev_reg <= 1'b0;
		end else begin
			warn_reg      <= (warn_reg & ~(sys_clr & readdata[cfmi_pkg::SB_WARN])) // RULE1
				| (sense.die_warn & ~warn_prev_reg);
			shut_reg      <= (shut_reg & ~(sys_clr & readdata[cfmi_pkg::SB_SHUT])) // RULE3
				| (sense.die_shutdown & ~shut_prev_reg);
			warn_prev_reg <= sense.die_warn;
			shut_prev_reg <= sense.die_shutdown;
		end
	end

	// Read data
	logic [31:0] sys_word;

	always_comb begin
		sys_word = 32'h0000_0000;
		sys_word[cfmi_pkg::SB_WARN]   = warn_reg;
		sys_word[cfmi_pkg::SB_SHUT]   = shut_reg;
		sys_word[cfmi_pkg::SB_PAUSED] = paused;
		sys_word[cfmi_pkg::SB_STATE +: 3] = state_reg;
	end

	// Unmapped reads return zero
	assign rd_value = sel_flags ? {16'h0000, flags_reg}
		: sel_masks ? {16'h0000, mask_reg}
		: sel_ctrl ? {24'h00_0000, ctrl_reg}
		: sel_sys ? sys_word
		: 32'h0000_0000;

	// Outputs, all registered
	logic        irq_next;
	logic        chg_next;

	assign irq_next = |(flags_next & ~mask_next); // RULE10 RULE16
	assign chg_next = ((state_next == CFMI_TRICKLE) || (state_next == CFMI_FAST))
		&& !paused && !sense.die_shutdown; // RULE1 RULE3 RULE17

	always_ff @(posedge clock) begin
		if (rst) begin
			readdata            <= 32'h0000_0000;
			waitrequest         <= 1'b1;
			charge_enable       <= 1'b0;
			trickle_mode        <= 1'b0;
			fast_mode           <= 1'b0;
			system_shutdown     <= 1'b0;
			charger_summary_irq <= 1'b0;
		end else begin
			readdata            <= (ack_next & read) ? rd_value : 32'h0000_0000;
			waitrequest         <= ~ack_next;
			charge_enable       <= chg_next;
			trickle_mode        <= state_next == CFMI_TRICKLE;
			fast_mode           <= state_next == CFMI_FAST;
			system_shutdown     <= state_next == CFMI_SHUTDOWN; // RULE3
			charger_summary_irq <= irq_next;
		end
	end

endmodule

// ### cfmi_charger_fault_monitor_asserts.sv
// Purpose: Port checks for the charger fault monitor
// Assumes: One clock, synchronous active-high reset
// Notes:   A mask shadow follows accepted mask writes, byte lanes 0 and 1
module cfmi_charger_fault_monitor_asserts (
	input wire logic                        clock,
	input wire logic                        rst,
	input wire logic [cfmi_pkg::ADDR_W-1:0] address,
	input wire logic                        read,
	input wire logic                        write,
	input wire logic [31:0]                 writedata,
	input wire logic [3:0]                  byteenable,
	input wire logic [31:0]                 readdata,
	input wire logic                        waitrequest,
	input wire cfmi_pkg::cfmi_sense_s       sense,
	input wire logic                        charge_enable,
	input wire logic                        trickle_mode,
	input wire logic                        fast_mode,
	input wire logic                        system_shutdown,
	input wire logic                        charger_summary_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mask_reg;
	logic [15:0] mask_next;
	wire         mask_hit = write && !waitrequest && address[9:2] == cfmi_pkg::IDX_MASKS;
	assign mask_next[7:0]  = (mask_hit && byteenable[0]) ? writedata[7:0] : mask_reg[7:0];
	assign mask_next[15:8] = (mask_hit && byteenable[1]) ? writedata[15:8] : mask_reg[15:8];
	always_ff @(posedge clock) begin
		if (rst)
			mask_reg <= cfmi_pkg::MASK_RESET;
		else
			mask_reg <= mask_next;
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// Exactly one wait state, answer stands one cycle
	sequence s_ack;
		!waitrequest ##1 waitrequest;
	endsequence
	a_ack_one_wait: assert property ((read || write) && waitrequest |=> s_ack)
		else $error("bus answer not after one wait state");
	a_idle_rdata: assert property (waitrequest |-> readdata == 32'h0000_0000)
		else $error("read data not zero while waiting");
	a_all_masked: assert property (&mask_reg |-> !charger_summary_irq)
		else $error("interrupt with every flag masked");
	a_hot_irq: assert property ($rose(sense.batt_hot) && !mask_reg[15] |=> charger_summary_irq)
		else $error("unmasked hot edge gave no interrupt");
	a_shut_enter: assert property (sense.die_shutdown |-> ##[1:2] system_shutdown && !charge_enable)
		else $error("die shutdown level not acted on");
	a_shut_sticky: assert property (system_shutdown |=> system_shutdown && !trickle_mode && !fast_mode)
		else $error("shutdown left or charging resumed");
	a_hot_pause: assert property (sense.batt_hot [*2] |-> !charge_enable)
		else $error("charging during hot battery");
	a_fast_drop: assert property (fast_mode && sense.batt_lt_low |-> ##[1:2] !fast_mode)
		else $error("fast charge kept on low battery");
endmodule

bind cfmi_charger_fault_monitor cfmi_charger_fault_monitor_asserts i_cfmi_charger_fault_monitor_asserts (
	.clock, .rst, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
	.sense, .charge_enable, .trickle_mode, .fast_mode, .system_shutdown, .charger_summary_irq);

// ### cfmi_host_model.sv
// Purpose: Host model issuing Avalon-MM register accesses
// Assumes: Each call starts just after a rising clock edge
// Notes:   Waits without limit; the bench watchdog cuts a hang
module cfmi_host_model (
	input  wire logic                        clock,
	input  wire logic [31:0]                 readdata,
	input  wire logic                        waitrequest,
	output logic      [cfmi_pkg::ADDR_W-1:0] address,
	output logic                             read,
	output logic                             write,
	output logic      [31:0]                 writedata,
	output logic      [3:0]                  byteenable
);
	timeunit 1ns;
	timeprecision 1ns;
	// No feedback flags reach this host, so undervoltage flags are trusted
	localparam logic TRUST_UV = 1'b1;
	initial begin
		address = '0;
		read = 1'b0;
		write = 1'b0;
		writedata = '0;
		byteenable = '0;
	end
	task automatic xfer(input logic is_wr, input logic [9:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		address <= a;
		read <= !is_wr;
		write <= is_wr;
		writedata <= d;
		byteenable <= be;
		@(posedge clock);
		while (waitrequest !== 1'b0)
			@(posedge clock);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		// Stale data would hide a lane slip
		writedata <= ~d;
		@(posedge clock);
	endtask
endmodule

// ### cfmi_charger_fault_monitor_tb_top.sv
// Purpose: Self-checking bench for the charger fault monitor
// Assumes: Host model drives the bus; bench drives sense levels
// Notes:   Trickle check point reached through a short MIN_CYC minute of 20 cycles
module cfmi_charger_fault_monitor_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [9:0] A_FLG = 10'h064;
	localparam logic [9:0] A_MSK = 10'h084;
	localparam logic [9:0] A_CTL = 10'h100;
	localparam logic [9:0] A_SYS = 10'h104;
	// Short minute so the trickle check point is reachable
	localparam int         MIN_T = 20;
	logic                  clock;
	logic                  rst;
	logic [9:0]            address;
	logic                  read;
	logic                  write;
	logic [31:0]           writedata;
	logic [3:0]            byteenable;
	logic [31:0]           readdata;
	logic                  waitrequest;
	cfmi_pkg::cfmi_sense_s sense;
	logic                  charge_enable;
	logic                  trickle_mode;
	logic                  fast_mode;
	logic                  system_shutdown;
	logic                  charger_summary_irq;
	logic [31:0]           q;
	int                    n_mismatch;
	int                    total_checks;
	int                    s_idx [8] = '{10, 9, 8, 7, 6, 2, 1, 0};
	int                    f_idx [8] = '{15, 14, 2, 1, 0, 9, 11, 12};
	cfmi_charger_fault_monitor #(.MIN_CYC(MIN_T)) i_cfmi_charger_fault_monitor (.clock, .rst, .address, .read,
		.write, .writedata, .byteenable, .readdata, .waitrequest, .sense, .charge_enable,
		.trickle_mode, .fast_mode, .system_shutdown, .charger_summary_irq);
	cfmi_host_model i_cfmi_host_model (.clock, .readdata, .waitrequest, .address, .read,
		.write, .writedata, .byteenable);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [9:0] a);
		i_cfmi_host_model.xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
		i_cfmi_host_model.xfer(1'b1, a, d, be, q);
	endtask
	task automatic print_verdict();
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic t_reset_regs();
		rd(A_MSK);
		check(q, {16'h0000, cfmi_pkg::MASK_RESET});
		wr(10'h3FC, 32'h0000_FFFF, 4'hF);
		rd(10'h3FC);
		check(q, 32'h0000_0000);
	endtask
	task automatic t_flag_table();
		for (int i = 0; i < 8; i++) begin
			sense[s_idx[i]] <= 1'b1;
			repeat (3) @(posedge clock);
			rd(A_FLG);
			check(q, 32'h0000_0001 << f_idx[i]);
			rd(A_FLG);
			check(q, 32'h0000_0000);
			sense[s_idx[i]] <= 1'b0;
			@(posedge clock);
		end
		check(32'(charger_summary_irq), 32'h0000_0000);
	endtask
	task automatic t_read_race();
		// Edge lands on the capture edge of this read, so the clear does not see it
		sense.batt_cold <= 1'b1;
		rd(A_FLG);
		check(q, 32'h0000_0000);
		rd(A_FLG);
		check(q, 32'h0000_4000);
		sense.batt_cold <= 1'b0;
	endtask
	task automatic t_irq_mask();
		wr(A_MSK, 32'h0000_7FFF, 4'h3);
		sense.batt_hot <= 1'b1;
		repeat (3) @(posedge clock);
		check(32'(charger_summary_irq), 32'h0000_0001);
		wr(A_MSK, 32'h0000_0000, 4'h1);
		rd(A_MSK);
		check(q, 32'h0000_7F00);
		rd(A_FLG);
		check(q, 32'h0000_8000);
		check(32'(charger_summary_irq), 32'h0000_0000);
		sense.batt_hot <= 1'b0;
		wr(A_MSK, 32'h0000_FFFF, 4'h3);
	endtask
	task automatic t_supply_lost();
		sense.batt_present <= 1'b1;
		sense.wall_present <= 1'b1;
		repeat (4) @(posedge clock);
		check(32'({trickle_mode, charge_enable}), 32'h0000_0003);
		rd(A_FLG);
		check(q & 32'h0000_0400, 32'h0000_0400);
		sense.wall_present <= 1'b0;
		repeat (3) @(posedge clock);
		rd(A_FLG);
		check(q & 32'h0000_0003, 32'h0000_0003);
		sense.wall_present <= 1'b1;
		repeat (4) @(posedge clock);
	endtask
	task automatic t_pauses();
		sense.die_warn <= 1'b1;
		repeat (3) @(posedge clock);
		check(32'(charge_enable), 32'h0000_0000);
		rd(10'h104);
		check(q & 32'h0000_0001, 32'h0000_0001);
		sense.die_warn <= 1'b0;
		repeat (3) @(posedge clock);
		check(32'(charge_enable), 32'h0000_0001);
		wr(A_CTL, 32'h0000_0001, 4'h1);
		sense.die_warn <= 1'b1;
		repeat (3) @(posedge clock);
		check(32'(charge_enable), 32'h0000_0001);
		sense.die_warn <= 1'b0;
		sense.batt_hot <= 1'b1;
		repeat (3) @(posedge clock);
		check(32'(charge_enable), 32'h0000_0000);
		sense.batt_hot <= 1'b0;
		repeat (3) @(posedge clock);
		check(32'({trickle_mode, charge_enable}), 32'h0000_0003);
	endtask
	task automatic t_batt_fail();
		sense.batt_lt_low <= 1'b1;
		wr(A_CTL, 32'h0000_0009, 4'h1);
		wr(A_CTL, 32'h0000_0001, 4'h1);
		repeat (29 * MIN_T) @(posedge clock);
		check(32'(trickle_mode), 32'h0000_0001);
		repeat (2 * MIN_T) @(posedge clock);
		check(32'({trickle_mode, charge_enable}), 32'h0000_0000);
		rd(A_FLG);
		check(q & 32'h0000_2000, 32'h0000_2000);
		sense.batt_lt_low <= 1'b0;
		repeat (3) @(posedge clock);
		check(32'({trickle_mode, charge_enable}), 32'h0000_0003);
		sense.batt_lt_low <= 1'b1;
		repeat (31 * MIN_T) @(posedge clock);
		rd(A_SYS);
		check(q & 32'h0000_0070, 32'h0000_0030);
		wr(A_CTL, 32'h0000_0009, 4'h1);
		rd(A_SYS);
		check(q & 32'h0000_0070, 32'h0000_0000);
		sense.batt_lt_low <= 1'b0;
		wr(A_CTL, 32'h0000_0001, 4'h1);
	endtask
	task automatic t_fast_shut();
		wr(A_CTL, 32'h0000_0003, 4'h1);
		sense.fast_ready <= 1'b1;
		repeat (3) @(posedge clock);
		check(32'(fast_mode), 32'h0000_0001);
		sense.batt_lt_low <= 1'b1;
		repeat (3) @(posedge clock);
		check(32'({fast_mode, trickle_mode}), 32'h0000_0001);
		sense.die_shutdown <= 1'b1;
		repeat (3) @(posedge clock);
		sense.die_shutdown <= 1'b0;
		repeat (3) @(posedge clock);
		check(32'({system_shutdown, charge_enable, trickle_mode}), 32'h0000_0004);
		rd(10'h104);
		check(q & 32'h0000_0002, 32'h0000_0002);
	endtask
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		#200000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		sense = '0;
		n_mismatch = 0;
		total_checks = 0;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_reset_regs();
		t_flag_table();
		t_read_race();
		t_irq_mask();
		t_supply_lost();
		t_pauses();
		t_batt_fail();
		t_fast_shut();
		print_verdict();
	end
endmodule
